// >>> rtl/sser_status.sv
// Status byte, service request enable and three event register sets
`timescale 1ns/10ps

module sser_status (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Host request and answer
    input wire sser_pkg::sser_req_type req,
    output sser_pkg::sser_rsp_type rsp,
    // Instrument events and live conditions
    input wire logic [7:0] std_event,
    input wire logic [15:0] ques_cond,
    input wire logic [15:0] ques_event,
    input wire logic [15:0] oper_cond,
    input wire logic [15:0] oper_event,
    input wire logic message_waiting,
    input wire logic error_pending,
    // Status outputs
    output logic [7:0] status_byte,
    output logic master_summary_flag
);
    import sser_pkg::*;

    logic [7:0] std_evt_reg, std_evt_next;
    logic [7:0] std_ena_reg, std_ena_next;
    logic [15:0] ques_evt_reg, ques_evt_next;
    logic [15:0] ques_ena_reg, ques_ena_next;
    logic [15:0] oper_evt_reg, oper_evt_next;
    logic [15:0] oper_ena_reg, oper_ena_next;
    logic [7:0] sre_reg, sre_next;
    logic [7:0] stb_reg, stb_next;
    logic msf_reg, msf_next;
    sser_rsp_type rsp_reg, rsp_next;
    logic [7:0] stb_live;
    logic std_sum, ques_sum, oper_sum;

    // Summary of one register set
    function automatic logic set_summary(input logic [15:0] evt, input logic [15:0] ena);
        set_summary = |(evt & ena);
    endfunction : set_summary

    // Event latch: set wins over clear so no event is lost
    function automatic logic [15:0] latch_evt(input logic [15:0] cur, input logic [15:0] ev, input logic clr);
        latch_evt = (clr ? 16'h0000 : cur) | ev;
    endfunction : latch_evt

    // Only the enable registers take host writes
    function automatic logic is_enable_sel(input sser_sel_type sel);
        is_enable_sel = sel == SSER_SEL_SRE || sel == SSER_SEL_STD_ENA
            || sel == SSER_SEL_QUES_ENA || sel == SSER_SEL_OPER_ENA;
    endfunction : is_enable_sel

    logic rd_std, rd_ques, rd_oper;
    logic wr_ok;

    always_comb begin
        rd_std = req.rd && req.sel == SSER_SEL_STD_EVT;
        rd_ques = req.rd && req.sel == SSER_SEL_QUES_EVT;
        rd_oper = req.rd && req.sel == SSER_SEL_OPER_EVT;
        wr_ok = is_enable_sel(req.sel);
    end

    // Event registers: cleared by their read or the clear-status command
    always_comb begin
        std_evt_next = 8'(latch_evt({8'h00, std_evt_reg}, {8'h00, std_event}, rd_std || req.clr_all));
        ques_evt_next = latch_evt(ques_evt_reg, ques_event, rd_ques || req.clr_all);
        oper_evt_next = latch_evt(oper_evt_reg, oper_event, rd_oper || req.clr_all);
    end

    // Enable registers, written with the weighted value sent by the host
    always_comb begin
        std_ena_next = std_ena_reg;
        ques_ena_next = ques_ena_reg;
        oper_ena_next = oper_ena_reg;
        sre_next = sre_reg;
        if (req.wr) begin
            unique case (req.sel)
                SSER_SEL_SRE: sre_next = req.wdata[7:0];
                SSER_SEL_STD_ENA: std_ena_next = req.wdata[7:0];
                SSER_SEL_QUES_ENA: ques_ena_next = req.wdata;
                SSER_SEL_OPER_ENA: oper_ena_next = req.wdata;
                default: ;
            endcase
        end
    end

    // Summaries follow the registered events; the status byte is registered and shows them one cycle later
    always_comb begin
        std_sum = set_summary({8'h00, std_evt_reg}, {8'h00, std_ena_reg});
        ques_sum = set_summary(ques_evt_reg, ques_ena_reg);
        oper_sum = set_summary(oper_evt_reg, oper_ena_reg);
        stb_live = 8'h00;
        stb_live[SB_OPER] = oper_sum;
        stb_live[SB_STD] = std_sum;
        stb_live[SB_MSG] = message_waiting;
        stb_live[SB_QUES] = ques_sum;
        stb_live[SB_ERR] = error_pending;
        msf_next = |(stb_live & sre_reg);
        stb_next = stb_live;
        stb_next[SB_MSF] = msf_next;
    end

    // Host answer, one cycle after the request
    always_comb begin
        rsp_next = '0;
        rsp_next.valid = req.rd || req.wr;
        rsp_next.refused = req.wr && !wr_ok;
        if (req.rd) begin
            unique case (req.sel)
                SSER_SEL_STB: rsp_next.rdata = {8'h00, stb_next};
                SSER_SEL_SRE: rsp_next.rdata = {8'h00, sre_reg};
                SSER_SEL_STD_EVT: rsp_next.rdata = {8'h00, std_evt_reg};
                SSER_SEL_STD_ENA: rsp_next.rdata = {8'h00, std_ena_reg};
                SSER_SEL_QUES_COND: rsp_next.rdata = ques_cond;
                SSER_SEL_QUES_EVT: rsp_next.rdata = ques_evt_reg;
                SSER_SEL_QUES_ENA: rsp_next.rdata = ques_ena_reg;
                SSER_SEL_OPER_COND: rsp_next.rdata = oper_cond;
                SSER_SEL_OPER_EVT: rsp_next.rdata = oper_evt_reg;
                SSER_SEL_OPER_ENA: rsp_next.rdata = oper_ena_reg;
                default: rsp_next.rdata = 16'h0000;
            endcase
        end
    end

    // Event registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            std_evt_reg <= SSER_RST8;
            ques_evt_reg <= SSER_RST16;
            oper_evt_reg <= SSER_RST16;
        end else begin
            std_evt_reg <= std_evt_next;
            ques_evt_reg <= ques_evt_next;
            oper_evt_reg <= oper_evt_next;
        end
    end

    // Enable registers and service request enable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            std_ena_reg <= SSER_RST8;
            ques_ena_reg <= SSER_RST16;
            oper_ena_reg <= SSER_RST16;
            sre_reg <= SSER_RST8;
        end else begin
            std_ena_reg <= std_ena_next;
            ques_ena_reg <= ques_ena_next;
            oper_ena_reg <= oper_ena_next;
            sre_reg <= sre_next;
        end
    end

    // Status byte and master flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stb_reg <= SSER_RST8;
            msf_reg <= 1'h0;
        end else begin
            stb_reg <= stb_next;
            msf_reg <= msf_next;
        end
    end

    // Host answer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign rsp = rsp_reg;
    assign status_byte = stb_reg;
    assign master_summary_flag = msf_reg;

    // Checks: event latching and clearing
    a_event_holds: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) && !$past(rd_std) && !$past(req.clr_all)
        |-> (std_evt_reg & $past(std_event)) == $past(std_event))
        else $error("standard event bit not latched");
    a_clear_status: assert property (@(posedge clock) disable iff (!rst_n)
        req.clr_all && std_event == 8'h00 && ques_event == 16'h0000 && oper_event == 16'h0000
        |=> std_evt_reg == 8'h00 && ques_evt_reg == 16'h0000 && oper_evt_reg == 16'h0000)
        else $error("clear-status left event bits set");
    a_event_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        ques_evt_reg[0] && !rd_ques && !req.clr_all
        |=> ques_evt_reg[0])
        else $error("event bit dropped without clear");
    a_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
        rd_ques
        |=> ques_evt_reg == $past(ques_event))
        else $error("questionable event read did not clear");
    a_std_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
        rd_std
        |=> std_evt_reg == $past(std_event))
        else $error("standard event read did not clear");
    a_oper_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
        rd_oper
        |=> oper_evt_reg == $past(oper_event))
        else $error("operation event read did not clear");
    a_stb_no_clear: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd && req.sel == SSER_SEL_STB && !req.clr_all
        |=> (std_evt_reg & $past(std_evt_reg)) == $past(std_evt_reg)
        && (ques_evt_reg & $past(ques_evt_reg)) == $past(ques_evt_reg)
        && (oper_evt_reg & $past(oper_evt_reg)) == $past(oper_evt_reg))
        else $error("status byte read cleared an event bit");
    a_read_only: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && !req.rd && !req.clr_all && req.sel == SSER_SEL_STD_EVT
        |=> std_evt_reg == ($past(std_evt_reg) | $past(std_event)))
        else $error("event register took a host write");

    // Checks: summaries and status byte
    a_summary_and: assert property (@(posedge clock) disable iff (!rst_n)
        1'h1
        |=> status_byte[SB_QUES] == $past(|(ques_evt_reg & ques_ena_reg)))
        else $error("questionable summary wrong");
    a_std_summary: assert property (@(posedge clock) disable iff (!rst_n)
        1'h1
        |=> status_byte[SB_STD] == $past(|(std_evt_reg & std_ena_reg)))
        else $error("standard summary wrong");
    a_oper_summary: assert property (@(posedge clock) disable iff (!rst_n)
        1'h1
        |=> status_byte[SB_OPER] == $past(|(oper_evt_reg & oper_ena_reg)))
        else $error("operation summary wrong");
    a_live_bits: assert property (@(posedge clock) disable iff (!rst_n)
        1'h1
        |=> status_byte[SB_MSG] == $past(message_waiting) && status_byte[SB_ERR] == $past(error_pending)
        && status_byte[1:0] == 2'h0)
        else $error("status byte live bits wrong");
    a_master_flag: assert property (@(posedge clock) disable iff (!rst_n)
        1'h1
        |=> master_summary_flag == |(status_byte & ~(8'h01 << SB_MSF) & $past(sre_reg)))
        else $error("master summary flag wrong");
    a_msf_in_byte: assert property (@(posedge clock) disable iff (!rst_n)
        status_byte[SB_MSF] == master_summary_flag)
        else $error("master flag not in status byte");

    // Checks: host access and reset
    a_write_refused: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && req.sel == SSER_SEL_QUES_COND
        |=> rsp.refused && rsp.valid)
        else $error("condition write not refused");
    a_enable_accepted: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && is_enable_sel(req.sel)
        |=> rsp.valid && !rsp.refused)
        else $error("enable write refused");
    a_no_spurious: assert property (@(posedge clock) disable iff (!rst_n)
        !req.rd && !req.wr
        |=> !rsp.valid && !rsp.refused && rsp.rdata == 16'h0000)
        else $error("answer without a request");
    a_sre_readback: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && req.sel == SSER_SEL_SRE ##1 !req.wr ##1 req.rd && req.sel == SSER_SEL_SRE && !req.wr
        |=> rsp.rdata == {8'h00, $past(req.wdata[7:0], 3)})
        else $error("service request enable readback wrong");
    a_sre_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !(req.wr && req.sel == SSER_SEL_SRE)
        |=> sre_reg == $past(sre_reg))
        else $error("service request enable changed without write");
    a_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
        req.wr && req.sel == SSER_SEL_QUES_ENA
        |=> ques_ena_reg == $past(req.wdata))
        else $error("questionable enable write lost");
    a_stb_read_data: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd && req.sel == SSER_SEL_STB
        |=> rsp.valid && rsp.rdata == {8'h00, status_byte})
        else $error("status byte read returned wrong value");
    a_cond_live: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd && req.sel == SSER_SEL_OPER_COND
        |=> rsp.rdata == $past(oper_cond))
        else $error("condition read not live");
    a_ques_cond_live: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd && req.sel == SSER_SEL_QUES_COND
        |=> rsp.rdata == $past(ques_cond))
        else $error("questionable condition read not live");
    a_reset_clear: assert property (@(posedge clock)
        !rst_n
        |=> sre_reg == 8'h00 && std_ena_reg == 8'h00 && std_evt_reg == 8'h00 && ques_evt_reg == 16'h0000
        && oper_evt_reg == 16'h0000 && status_byte == 8'h00 && !rsp.valid)
        else $error("reset left state set");

    c_msf_set: cover property (@(posedge clock) disable iff (!rst_n) $rose(master_summary_flag));
    c_evt_read_clear: cover property (@(posedge clock) disable iff (!rst_n) ques_evt_reg != 16'h0000 && rd_ques);
    c_clear_status: cover property (@(posedge clock) disable iff (!rst_n) req.clr_all && std_evt_reg != 8'h00);
    c_refused: cover property (@(posedge clock) disable iff (!rst_n) rsp.refused);
    c_stb_read: cover property (@(posedge clock) disable iff (!rst_n) req.rd && req.sel == SSER_SEL_STB && master_summary_flag);
endmodule : sser_status

// >>> rtl/sser_pkg.sv
// Package for the status and event reporting block: widths, bit positions, commands, reset values
package sser_pkg;
    localparam int SSER_W = 8;
    localparam int QUES_W = 16;
    localparam int OPER_W = 16;
    // Status byte bit positions
    localparam int SB_OPER = 7;
    localparam int SB_MSF = 6;
    localparam int SB_STD = 5;
    localparam int SB_MSG = 4;
    localparam int SB_QUES = 3;
    localparam int SB_ERR = 2;
    // Reset values
    localparam logic [7:0] SSER_RST8 = 8'h00;
    localparam logic [15:0] SSER_RST16 = 16'h0000;

    // Register selectors for host access
    typedef enum logic [3:0] {
        SSER_SEL_STB,
        SSER_SEL_SRE,
        SSER_SEL_STD_EVT,
        SSER_SEL_STD_ENA,
        SSER_SEL_QUES_COND,
        SSER_SEL_QUES_EVT,
        SSER_SEL_QUES_ENA,
        SSER_SEL_OPER_COND,
        SSER_SEL_OPER_EVT,
        SSER_SEL_OPER_ENA
    } sser_sel_type;

    // Host request
    typedef struct packed {
        logic rd;
        logic wr;
        logic clr_all;
        sser_sel_type sel;
        logic [15:0] wdata;
    } sser_req_type;

    // Host answer
    typedef struct packed {
        logic valid;
        logic refused;
        logic [15:0] rdata;
    } sser_rsp_type;
endpackage : sser_pkg

// >>> verification/sser_host_model.sv
// Host model issuing status queries, enable writes and clear-status commands
`timescale 1ns/10ps
module sser_host_model (
    // Clock
    input wire logic clock,
    // Request and answer
    output sser_pkg::sser_req_type req,
    input wire sser_pkg::sser_rsp_type rsp
);
    import sser_pkg::*;
    sser_rsp_type last_rsp;
    initial begin
        req = '0;
        last_rsp = '0;
    end
    // One request per call; the answer is taken one edge later, when it stands
    task automatic access(input logic rd, input logic wr, input logic clr, input sser_sel_type sel,
        input logic [15:0] val);
        @(posedge clock);
        #1;
        req <= '{rd: rd, wr: wr, clr_all: clr, sel: sel, wdata: val};
        @(posedge clock);
        #1;
        req <= '0;
        last_rsp = rsp;
    endtask : access
endmodule : sser_host_model

// >>> verification/test_sser_status.sv
// Testbench for the status and event reporting block
`timescale 1ns/10ps
module test_sser_status;
    import sser_pkg::*;
    typedef struct packed {
        logic rd;
        logic wr;
        sser_sel_type sel;
        logic [15:0] wdata;
        logic refused;
        logic [15:0] rdata;
    } sser_row_type;
    logic clock;
    logic rst_n;
    sser_req_type req;
    sser_rsp_type rsp;
    logic [7:0] std_event;
    logic [15:0] ques_cond, ques_event, oper_cond, oper_event;
    logic message_waiting, error_pending, master_summary_flag;
    logic [7:0] status_byte;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    sser_row_type rows [15] = '{
        '{1'h0, 1'h1, SSER_SEL_SRE, 16'h00A5, 1'h0, 16'h0000},
        '{1'h1, 1'h0, SSER_SEL_SRE, 16'h0000, 1'h0, 16'h00A5},
        '{1'h0, 1'h1, SSER_SEL_STB, 16'h00FF, 1'h1, 16'h0000},
        '{1'h0, 1'h1, SSER_SEL_STD_EVT, 16'h00FF, 1'h1, 16'h0000},
        '{1'h0, 1'h1, SSER_SEL_QUES_COND, 16'h00FF, 1'h1, 16'h0000},
        '{1'h0, 1'h1, SSER_SEL_QUES_EVT, 16'h00FF, 1'h1, 16'h0000},
        '{1'h0, 1'h1, SSER_SEL_OPER_COND, 16'h00FF, 1'h1, 16'h0000},
        '{1'h0, 1'h1, SSER_SEL_OPER_EVT, 16'h00FF, 1'h1, 16'h0000},
        '{1'h0, 1'h1, SSER_SEL_STD_ENA, 16'h00FF, 1'h0, 16'h0000},
        '{1'h1, 1'h0, SSER_SEL_STD_ENA, 16'h0000, 1'h0, 16'h00FF},
        '{1'h0, 1'h1, SSER_SEL_QUES_ENA, 16'h8001, 1'h0, 16'h0000},
        '{1'h1, 1'h0, SSER_SEL_QUES_ENA, 16'h0000, 1'h0, 16'h8001},
        '{1'h0, 1'h1, SSER_SEL_OPER_ENA, 16'hFFFF, 1'h0, 16'h0000},
        '{1'h1, 1'h0, SSER_SEL_OPER_ENA, 16'h0000, 1'h0, 16'hFFFF},
        '{1'h1, 1'h0, SSER_SEL_QUES_COND, 16'h0000, 1'h0, 16'h1234}
    };
    sser_status i_sser_status (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp), .std_event(std_event),
        .ques_cond(ques_cond), .ques_event(ques_event), .oper_cond(oper_cond), .oper_event(oper_event),
        .message_waiting(message_waiting), .error_pending(error_pending), .status_byte(status_byte),
        .master_summary_flag(master_summary_flag));
    sser_host_model i_sser_host_model (.clock(clock), .req(req), .rsp(rsp));
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic xs(input logic rd, input logic wr, input logic clr, input sser_sel_type sel, input logic [15:0] v);
        i_sser_host_model.access(rd, wr, clr, sel, v);
    endtask : xs
    task automatic chk_rsp(input logic refused, input logic [15:0] data);
        sser_rsp_type got;
        got = i_sser_host_model.last_rsp;
        n_checks++;
        if (got !== {1'h1, refused, data}) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, {1'h1, refused, data});
        end
    endtask : chk_rsp
    task automatic chk_stat(input logic [7:0] exp);
        n_checks++;
        if (status_byte !== exp || master_summary_flag !== exp[6]) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, {master_summary_flag, status_byte}, exp);
        end
    endtask : chk_stat
    initial begin
        rst_n = 1'h0;
        {std_event, ques_event, oper_event, message_waiting, error_pending} = '0;
        ques_cond = 16'h1234;
        oper_cond = 16'hBEEF;
        tick(10);
        rst_n = 1'h1;
        chk_stat(8'h00);
        foreach (rows[i]) begin
            xs(rows[i].rd, rows[i].wr, 1'h0, rows[i].sel, rows[i].wdata);
            chk_rsp(rows[i].refused, rows[i].rdata);
        end
        oper_cond = 16'h0F0F;
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_OPER_COND, 16'h0000);
        chk_rsp(1'h0, 16'h0F0F);
        ques_event = 16'h0001;
        tick(1);
        ques_event = 16'h0000;
        tick(2);
        chk_stat(8'h08);
        xs(1'h0, 1'h1, 1'h0, SSER_SEL_SRE, 16'h0008);
        tick(1);
        chk_stat(8'h48);
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_STB, 16'h0000);
        chk_rsp(1'h0, 16'h0048);
        ques_event = 16'h0001;
        tick(2);
        ques_event = 16'h0000;
        chk_stat(8'h48);
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_QUES_EVT, 16'h0000);
        chk_rsp(1'h0, 16'h0001);
        tick(1);
        chk_stat(8'h00);
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_QUES_EVT, 16'h0000);
        chk_rsp(1'h0, 16'h0000);
        {std_event, oper_event, message_waiting, error_pending} = {8'h20, 16'h0040, 2'h3};
        tick(1);
        {std_event, oper_event} = '0;
        tick(2);
        chk_stat(8'hB4);
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_STD_EVT, 16'h0000);
        chk_rsp(1'h0, 16'h0020);
        xs(1'h0, 1'h0, 1'h1, SSER_SEL_STB, 16'h0000);
        tick(1);
        chk_stat(8'h14);
        oper_event = 16'h0040;
        tick(1);
        oper_event = 16'h0000;
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_OPER_EVT, 16'h0000);
        chk_rsp(1'h0, 16'h0040);
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_OPER_EVT, 16'h0000);
        chk_rsp(1'h0, 16'h0000);
        rst_n = 1'h0;
        tick(2);
        rst_n = 1'h1;
        xs(1'h1, 1'h0, 1'h0, SSER_SEL_SRE, 16'h0000);
        chk_rsp(1'h0, 16'h0000);
        wrap_up();
    end
endmodule : test_sser_status
